//--- rtl/low_power_os_tick_timer.sv
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - 32-bit counter decrements on slow timer clock, usable in any sleep state that keeps the system clock running.
// - Count going from one to zero emits one expiry interrupt pulse.
// - Setting count_go loads reload value and starts; one-shot when continuous_reload clear.
// - After one-shot expiry, setting count_go again restarts from unchanged reload.
// - Continuous mode reloads at zero, keeps counting, pulses on every expiry.
// - Reload writes while running leave current count; used at next reload.
// - Reload written zero while counting: finish to zero, then clear count_go.
// - Setting count_go with zero reload self-clears count_go, no counting.
// - Debug halt high with gate enabled stops counting; resumes from held value.
// - Control bit 4 fw_halt_bit freezes counter when one.
// - Control bit 3 hw_halt_gate_en lets debug halt stop counter.
// - Count register returns live count, no snapshot; read as one word.
// - clk_request high only during register access or interrupt delivery.
// - sleep_request input ignored entirely.
// - Counting needs the system clock running, since it samples the slow clock pin.
// - Power-on reset zeroes all registers and logic, stopping any count.
// - count_go set loads and starts; firmware clear zeroes count, no interrupt.
// - continuous_reload zero is one-shot with done state; one is continuous.
// - unit_enable zero gates counting; falling edge returns everything to defaults.
module low_power_os_tick_timer #(
  parameter int unsigned COUNT_W = 32
) (
  // clock and power-on reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // slow timer clock pin, sampled as a level
  input wire logic slow_timer_clk_i,
  // debug halt and sleep sideband
  input wire logic dbg_halt_i,
  input wire logic sleep_request_i,
  // register access port
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [tick_timer_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [3:0] reg_be_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ready_o,
  // interrupt and clock request
  output logic tick_expiry_irq_o,
  output logic clk_request_o
);

  // synchronised pin levels
  logic slow_lvl;
  logic slow_lvl_d;
  logic slow_tick;
  logic halt_lvl;

  // software visible state
  logic [COUNT_W-1:0] live_count_value;
  logic [COUNT_W-1:0] reload_value;
  logic unit_enable;
  logic continuous_reload;
  logic count_go;
  logic hw_halt_gate_en;
  logic fw_halt_bit;

  // access decode
  logic wr_any;
  logic wr_ctrl;
  logic wr_reload;
  logic rd_any;
  logic [31:0] rd_word;

  // control write decode
  logic new_enable;
  logic new_go;
  logic enable_fall;
  logic go_rise;
  logic go_fw_clear;

  // counting logic
  logic halted;
  logic count_step;
  logic reload_zero;
  logic at_last;
  logic at_zero;
  logic expire;
  logic [COUNT_W-1:0] next_count;
  logic next_go;
  tick_timer_pkg::tmr_state_t tmr_state;
  tick_timer_pkg::tmr_state_t next_state;

  // sleep_request_i is deliberately left unread: it has no effect here

  // slow clock pin through the three-flop filter; the pin is sampled as data,
  // so each of its phases must outlast several system clocks, and a tick
  // reaches the counter about four system clocks after the pin rises
  pin_sync3 slow_clk_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(slow_timer_clk_i),
    .level_o(slow_lvl)
  );

  // debug halt pin through the three-flop filter
  // the halt pin moves slowly against the tick spacing, so the same filter suffices
  pin_sync3 halt_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(dbg_halt_i),
    .level_o(halt_lvl)
  );

  // previous filtered slow clock level, for rising edge detection
  // its reset level matches the idle pin level, so no false tick follows reset
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slow_lvl_d <= tick_timer_pkg::SYNC_LEVEL_RST;
    end else begin
      slow_lvl_d <= slow_lvl;
    end
  end

  // one tick per rising edge of the slow timer clock
  assign slow_tick = slow_lvl & ~slow_lvl_d;

  // register access decode
  assign wr_any = reg_sel_i & reg_wr_i;
  assign rd_any = reg_sel_i & ~reg_wr_i;
  assign wr_ctrl = wr_any & reg_be_i[0] & (reg_addr_i == tick_timer_pkg::OFS_TICK_CONTROL);
  assign wr_reload = wr_any & (reg_addr_i == tick_timer_pkg::OFS_RELOAD);

  // control write edges on enable and go; go acts only on its edges, so rewriting
  // a set go bit leaves a running count alone, and every control bit sits in lane 0
  assign new_enable = reg_wdata_i[tick_timer_pkg::CTL_UNIT_ENABLE];
  assign new_go = reg_wdata_i[tick_timer_pkg::CTL_COUNT_GO];
  assign enable_fall = wr_ctrl & unit_enable & ~new_enable;
  assign go_rise = wr_ctrl & ~count_go & new_go;
  assign go_fw_clear = wr_ctrl & count_go & ~new_go;

  // halt sources: firmware bit alone, or debug pin when gated in
  // a halt only withholds steps; the count and the tick detector keep their state
  assign halted = fw_halt_bit | (hw_halt_gate_en & halt_lvl);

  // counting advances only when enabled, running, unhalted and on a tick
  assign count_step = count_go & unit_enable & slow_tick & ~halted;
  assign reload_zero = (reload_value == COUNT_W'(tick_timer_pkg::COUNT_ZERO));

  // terminal count detection, compared once here rather than inside the step decode
  assign at_last = (live_count_value == COUNT_W'(tick_timer_pkg::COUNT_LAST));
  assign at_zero = (live_count_value == COUNT_W'(tick_timer_pkg::COUNT_ZERO));

  // next count, go bit, state and expiry for this cycle
  always_comb begin
    next_count = live_count_value;
    next_go = count_go;
    next_state = tmr_state;
    expire = 1'b0;
    // priority: disabling, then a firmware clear, then a start, then a counting step;
    // a disable, firmware clear or start therefore beats a tick that lands in the same cycle
    if (enable_fall) begin
      next_count = COUNT_W'(tick_timer_pkg::LIVE_COUNT_RST);
      next_go = 1'b0;
      next_state = tick_timer_pkg::ST_IDLE;
    end else if (go_fw_clear) begin
      next_count = COUNT_W'(tick_timer_pkg::COUNT_ZERO);
      next_go = 1'b0;
      next_state = tick_timer_pkg::ST_IDLE;
    end else if (go_rise) begin
      if (reload_zero) begin
        next_go = 1'b0;
        next_state = tick_timer_pkg::ST_IDLE;
      end else begin
        next_count = reload_value;
        next_go = 1'b1;
        next_state = tick_timer_pkg::ST_RUN;
      end
    end else if (count_step) begin
      // the one-to-zero step is the only place the expiry pulse is raised
      if (at_last) begin
        next_count = COUNT_W'(tick_timer_pkg::COUNT_ZERO);
        expire = 1'b1;
        if (!continuous_reload) begin
          next_go = 1'b0;
          next_state = tick_timer_pkg::ST_DONE;
        end
      end else if (at_zero) begin
        // continuous mode rests at zero for one tick, then takes the latest reload value
        if (continuous_reload && !reload_zero) begin
          next_count = reload_value;
          next_state = tick_timer_pkg::ST_RUN;
        end else begin
          next_go = 1'b0;
          next_state = tick_timer_pkg::ST_DONE;
        end
      end else begin
        // plain decrement; no wrap, since zero is handled above
        next_count = live_count_value - COUNT_W'(1);
      end
    end
  end

  // live counter, reset to zero by power-on reset
  // every change is decided in the combinational block above, one source per cycle
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      live_count_value <= COUNT_W'(tick_timer_pkg::LIVE_COUNT_RST);
    end else begin
      live_count_value <= next_count;
    end
  end

  // count_go bit, set by firmware, cleared by firmware or hardware
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_go <= tick_timer_pkg::TICK_CONTROL_RST[tick_timer_pkg::CTL_COUNT_GO];
    end else begin
      count_go <= next_go;
    end
  end

  // sequencing state, idle, running or done after a count runs out
  // the done state marks a finished count until go is set again or the unit is disabled
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tmr_state <= tick_timer_pkg::ST_IDLE;
    end else begin
      case (next_state)
        tick_timer_pkg::ST_IDLE: begin
          tmr_state <= tick_timer_pkg::ST_IDLE;
        end
        tick_timer_pkg::ST_RUN: begin
          tmr_state <= tick_timer_pkg::ST_RUN;
        end
        tick_timer_pkg::ST_DONE: begin
          tmr_state <= tick_timer_pkg::ST_DONE;
        end
        default: begin
          tmr_state <= tick_timer_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // remaining control bits, plain firmware storage
  // a falling enable clears every bit, which also drops any halt selection
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unit_enable <= tick_timer_pkg::TICK_CONTROL_RST[tick_timer_pkg::CTL_UNIT_ENABLE];
      continuous_reload <= tick_timer_pkg::TICK_CONTROL_RST[tick_timer_pkg::CTL_CONT_RELOAD];
      hw_halt_gate_en <= tick_timer_pkg::TICK_CONTROL_RST[tick_timer_pkg::CTL_HW_HALT_GATE];
      fw_halt_bit <= tick_timer_pkg::TICK_CONTROL_RST[tick_timer_pkg::CTL_FW_HALT];
    end else if (enable_fall) begin
      unit_enable <= 1'b0;
      continuous_reload <= 1'b0;
      hw_halt_gate_en <= 1'b0;
      fw_halt_bit <= 1'b0;
    end else if (wr_ctrl) begin
      unit_enable <= new_enable;
      continuous_reload <= reg_wdata_i[tick_timer_pkg::CTL_CONT_RELOAD];
      hw_halt_gate_en <= reg_wdata_i[tick_timer_pkg::CTL_HW_HALT_GATE];
      fw_halt_bit <= reg_wdata_i[tick_timer_pkg::CTL_FW_HALT];
    end
  end

  // reload register, byte lanes written independently, never touches the count
  // a zero written while running lets the count run out, then go is cleared
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reload_value <= COUNT_W'(tick_timer_pkg::RELOAD_RST);
    end else if (enable_fall) begin
      reload_value <= COUNT_W'(tick_timer_pkg::RELOAD_RST);
    end else if (wr_reload) begin
      for (int b = 0; b < COUNT_W / 8; b++) begin
        if (reg_be_i[b]) begin
          reload_value[b*8 +: 8] <= reg_wdata_i[b*8 +: 8];
        end
      end
    end
  end

  // read multiplexer, count is the live value with no snapshot
  // unmapped offsets and the unused control bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (reg_addr_i)
      tick_timer_pkg::OFS_LIVE_COUNT: begin
        rd_word = 32'(live_count_value);
      end
      tick_timer_pkg::OFS_RELOAD: begin
        rd_word = 32'(reload_value);
      end
      tick_timer_pkg::OFS_TICK_CONTROL: begin
        rd_word[tick_timer_pkg::CTL_UNIT_ENABLE] = unit_enable;
        rd_word[tick_timer_pkg::CTL_CONT_RELOAD] = continuous_reload;
        rd_word[tick_timer_pkg::CTL_COUNT_GO] = count_go;
        rd_word[tick_timer_pkg::CTL_HW_HALT_GATE] = hw_halt_gate_en;
        rd_word[tick_timer_pkg::CTL_FW_HALT] = fw_halt_bit;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // read data registered whole, so a word read sees one consistent value
  // it changes only on reads, so it may be picked up any time before the next read
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= tick_timer_pkg::RDATA_RST;
    end else if (rd_any) begin
      reg_rdata_o <= rd_word;
    end
  end

  // access completion, one cycle after any selected access
  // fixed latency with no wait states, so one access per cycle is allowed
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_ready_o <= 1'b0;
    end else begin
      reg_ready_o <= reg_sel_i;
    end
  end

  // expiry pulse, one system clock cycle per one-to-zero transition
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_expiry_irq_o <= 1'b0;
    end else begin
      tick_expiry_irq_o <= expire;
    end
  end

  // clock request only around accesses and interrupt delivery
  // it stays up from the expiry decision until the pulse has been delivered
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_request_o <= 1'b0;
    end else begin
      clk_request_o <= reg_sel_i | reg_ready_o | expire | tick_expiry_irq_o;
    end
  end

endmodule

`default_nettype wire

//--- rtl/pin_sync3.sv
`timescale 1ns/10ps
`default_nettype none

module pin_sync3 (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // asynchronous pin in, filtered level out
  input wire logic async_i,
  output logic level_o
);

  logic stage1;
  logic stage2;
  logic stage3;

  // three-flop chain, the first flop feeds only the second
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1 <= tick_timer_pkg::SYNC_LEVEL_RST;
      stage2 <= tick_timer_pkg::SYNC_LEVEL_RST;
      stage3 <= tick_timer_pkg::SYNC_LEVEL_RST;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change is accepted once the second and third stages agree
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_o <= tick_timer_pkg::SYNC_LEVEL_RST;
    end else if (stage2 == stage3) begin
      level_o <= stage3;
    end
  end

endmodule

`default_nettype wire

//--- rtl/tick_timer_pkg.sv
package tick_timer_pkg;

  // register map, byte offsets on the internal register port
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_LIVE_COUNT = 8'h00;
  localparam logic [7:0] OFS_RELOAD = 8'h04;
  localparam logic [7:0] OFS_TICK_CONTROL = 8'h08;

  // tick_control field positions
  localparam int unsigned CTL_UNIT_ENABLE = 0;
  localparam int unsigned CTL_CONT_RELOAD = 1;
  localparam int unsigned CTL_COUNT_GO = 2;
  localparam int unsigned CTL_HW_HALT_GATE = 3;
  localparam int unsigned CTL_FW_HALT = 4;
  localparam int unsigned CTL_USED_W = 5;

  // values after reset
  localparam logic [31:0] LIVE_COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] RELOAD_RST = 32'h0000_0000;
  localparam logic [4:0] TICK_CONTROL_RST = 5'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic SYNC_LEVEL_RST = 1'b0;

  // count value at which the expiry pulse fires on the next tick
  localparam logic [31:0] COUNT_LAST = 32'h0000_0001;
  localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;

  // timer sequencing states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } tmr_state_t;

endpackage

//--- tb/ec_bus_model.sv
`timescale 1ns/10ps
`default_nettype none

module ec_bus_model (
  // clock
  input wire logic sys_clk_i,
  // answer from the timer
  input wire logic reg_ready_i,
  input wire logic [31:0] reg_rdata_i,
  // request to the timer
  output logic reg_sel_o,
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [3:0] reg_be_o,
  output logic [31:0] reg_wdata_o
);
  // idle bus at time zero
  initial begin
    reg_sel_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h0;
    reg_be_o = 4'h0;
    reg_wdata_o = 32'h0;
  end

  // one access: one-cycle select, hold qualifiers until ready is sampled
  task access(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q, output logic ok);
    int n;
    @(negedge sys_clk_i);
    reg_sel_o = 1'b1;
    reg_wr_o = wr;
    reg_addr_o = a;
    reg_be_o = be;
    reg_wdata_o = d;
    @(negedge sys_clk_i);
    reg_sel_o = 1'b0;
    n = 0;
    while (reg_ready_i !== 1'b1 && n < 8) begin
      @(negedge sys_clk_i);
      n++;
    end
    // a missing answer is reported to the caller, which counts it as a mismatch
    ok = (reg_ready_i === 1'b1);
    q = reg_rdata_i;
    @(negedge sys_clk_i);
    // released lines no longer show the last value
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
    reg_be_o = 4'h0;
  endtask
endmodule

`default_nettype wire

//--- tb/low_power_os_tick_timer_test.sv
`timescale 1ns/10ps
`default_nettype none

module low_power_os_tick_timer_test;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic slow_timer_clk_i = 1'b0;
  logic dbg_halt_i = 1'b0;
  logic sleep_request_i = 1'b0;
  logic reg_sel, reg_wr, reg_ready, irq, clk_req;
  logic [7:0] reg_addr;
  logic [3:0] reg_be;
  logic [31:0] reg_wdata, reg_rdata;
  int mismatches = 0;
  int n_tests = 0;
  int irq_seen = 0;

  // 100 MHz system clock
  always #5 sys_clk_i = ~sys_clk_i;

  low_power_os_tick_timer #(.COUNT_W(32)) DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .slow_timer_clk_i(slow_timer_clk_i), .dbg_halt_i(dbg_halt_i),
    .sleep_request_i(sleep_request_i), .reg_sel_i(reg_sel), .reg_wr_i(reg_wr),
    .reg_addr_i(reg_addr), .reg_be_i(reg_be), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .reg_ready_o(reg_ready), .tick_expiry_irq_o(irq),
    .clk_request_o(clk_req));

  ec_bus_model u_ec (.sys_clk_i(sys_clk_i), .reg_ready_i(reg_ready), .reg_rdata_i(reg_rdata),
    .reg_sel_o(reg_sel), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr), .reg_be_o(reg_be),
    .reg_wdata_o(reg_wdata));

  // expiry pulse counter, sampled mid-cycle where the pulse is settled
  always @(negedge sys_clk_i) if (irq === 1'b1) irq_seen++;

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wrbe(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    logic ok;
    u_ec.access(1'b1, a, d, be, q, ok);
    check("write ready", {31'h0, ok}, 32'h1);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    wrbe(a, d, 4'hf);
  endtask

  task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic ok;
    u_ec.access(1'b0, a, 32'h0, 4'hf, q, ok);
    check("read ready", {31'h0, ok}, 32'h1);
    check(what, q, exp);
  endtask

  // slow timer clock pulses, still between them
  task tick(input int n);
    repeat (n) begin
      @(negedge sys_clk_i);
      slow_timer_clk_i = 1'b1;
      repeat (8) @(negedge sys_clk_i);
      slow_timer_clk_i = 1'b0;
      repeat (8) @(negedge sys_clk_i);
    end
  endtask

  task t_defaults;
    rchk("count", 8'h00, 32'h0);
    rchk("reload", 8'h04, 32'h0);
    rchk("ctrl", 8'h08, 32'h0);
    wr(8'h00, 32'h1234_5678);
    rchk("count ro", 8'h00, 32'h0);
    rchk("unmapped", 8'h0c, 32'h0);
    wr(8'h08, 32'h0000_0005);
    rchk("go zero reload", 8'h08, 32'h1);
    rchk("count idle", 8'h00, 32'h0);
  endtask

  task t_oneshot;
    int i0;
    i0 = irq_seen;
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h5);
    rchk("load", 8'h00, 32'h3);
    tick(1);
    rchk("dec", 8'h00, 32'h2);
    tick(3);
    check("irq once", irq_seen - i0, 1);
    rchk("done ctrl", 8'h08, 32'h1);
    rchk("done count", 8'h00, 32'h0);
    wr(8'h08, 32'h5);
    rchk("restart", 8'h00, 32'h3);
    wr(8'h08, 32'h1);
    rchk("fw stop", 8'h00, 32'h0);
    check("no stop irq", irq_seen - i0, 1);
  endtask

  task t_continuous;
    int i0;
    i0 = irq_seen;
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h7);
    wr(8'h04, 32'h4);
    rchk("count kept", 8'h00, 32'h2);
    tick(3);
    rchk("reloaded new", 8'h00, 32'h4);
    check("irq cont", irq_seen - i0, 1);
    wr(8'h04, 32'h0);
    tick(4);
    rchk("still go", 8'h08, 32'h7);
    check("irq again", irq_seen - i0, 2);
    tick(1);
    rchk("go cleared", 8'h08, 32'h3);
  endtask

  task t_halts;
    sleep_request_i = 1'b1;
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h15);
    tick(1);
    rchk("fw halt", 8'h00, 32'h5);
    dbg_halt_i = 1'b1;
    wr(8'h08, 32'h0d);
    tick(1);
    rchk("hw halt", 8'h00, 32'h5);
    wr(8'h08, 32'h05);
    tick(1);
    rchk("gate off", 8'h00, 32'h4);
    wr(8'h08, 32'h0d);
    tick(1);
    dbg_halt_i = 1'b0;
    tick(1);
    rchk("resume", 8'h00, 32'h3);
    repeat (4) @(negedge sys_clk_i);
    check("clk req idle", {31'h0, clk_req}, 32'h0);
    wr(8'h08, 32'h0);
    rchk("disable reload", 8'h04, 32'h0);
    rchk("disable count", 8'h00, 32'h0);
    sleep_request_i = 1'b0;
  endtask

  task t_midrun_reset;
    wrbe(8'h04, 32'haabb_ccdd, 4'h5);
    rchk("reload lanes", 8'h04, 32'h00bb_00dd);
    wrbe(8'h08, 32'h0000_0001, 4'he);
    rchk("ctrl lane0 off", 8'h08, 32'h0);
    wr(8'h04, 32'h7);
    wr(8'h08, 32'h5);
    @(negedge sys_clk_i);
    rst_b_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    tick(1);
    rchk("rst count", 8'h00, 32'h0);
    rchk("rst ctrl", 8'h08, 32'h0);
    rchk("rst reload", 8'h04, 32'h0);
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    t_defaults();
    t_oneshot();
    t_continuous();
    t_halts();
    t_midrun_reset();
    complete_run();
  end

  // watchdog
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
endmodule

bind low_power_os_tick_timer tick_timer_checker #(.COUNT_W(COUNT_W)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .slow_timer_clk_i(slow_timer_clk_i),
  .dbg_halt_i(dbg_halt_i), .sleep_request_i(sleep_request_i), .reg_sel_i(reg_sel_i),
  .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_ready_o(reg_ready_o),
  .tick_expiry_irq_o(tick_expiry_irq_o), .clk_request_o(clk_request_o));

`default_nettype wire

//--- tb/tick_timer_checker.sv
`timescale 1ns/10ps
`default_nettype none

module tick_timer_checker #(
  parameter int unsigned COUNT_W = 32
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // watched inputs
  input wire logic slow_timer_clk_i,
  input wire logic dbg_halt_i,
  input wire logic sleep_request_i,
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [tick_timer_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [3:0] reg_be_i,
  input wire logic [31:0] reg_wdata_i,
  // watched outputs
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_ready_o,
  input wire logic tick_expiry_irq_o,
  input wire logic clk_request_o
);
  logic [2:0] busy_hist;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  // recent access or expiry activity
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_hist <= 3'h0;
    end else begin
      busy_hist <= {busy_hist[1:0], reg_sel_i | reg_ready_o | tick_expiry_irq_o};
    end
  end

  AST_READY_AFTER_SEL: assert property (reg_sel_i |=> reg_ready_o)
    else $error("no ready one cycle after access");
  AST_READY_CAUSE: assert property (reg_ready_o |-> $past(reg_sel_i))
    else $error("ready without access");
  AST_IRQ_SINGLE: assert property (tick_expiry_irq_o |=> !tick_expiry_irq_o [*3])
    else $error("expiry pulse longer than one cycle");
  AST_CLKREQ_ACCESS: assert property (reg_sel_i |=> clk_request_o [*2])
    else $error("clock request missing during access");
  AST_CLKREQ_IDLE: assert property (clk_request_o |->
      (busy_hist != 3'h0) or (##[0:2] tick_expiry_irq_o))
    else $error("clock request while idle");
  AST_RDATA_HOLD: assert property ($past(!reg_sel_i || reg_wr_i) |-> $stable(reg_rdata_o))
    else $error("read data changed without read");
  AST_UNMAPPED_ZERO: assert property (reg_sel_i && !reg_wr_i &&
      !(reg_addr_i inside {8'h00, 8'h04, 8'h08}) |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_CTRL_UPPER_ZERO: assert property (reg_sel_i && !reg_wr_i && reg_addr_i == 8'h08
      |=> reg_rdata_o[31:5] == 27'h0)
    else $error("control upper bits not zero");
endmodule

`default_nettype wire
